// >>> hdl/mcu_timer_counters.sv
// Timers 0, 1 and 2 with their special function registers
//
// Overview of operation
// RQ1: Mode 2 gives 8-bit auto-reload counters
// RQ2: Mode 3 splits timer 0; timer 1 holds
// RQ3: Timer 0 split: timer 1 raises no flag
// RQ4: Timer 2 is 16-bit, live-readable, reloadable
// RQ5: Timer 2 timer mode: every 12/24 cycles
// RQ6: Event mode counts sampled 1-to-0 transitions
// RQ7: Event increment lands one cycle after detection
// RQ8: Gated mode counts only while input high
// RQ9: Reload mode 0 reloads on overflow
// RQ10: Reload mode 1 reloads on trigger fall
// RQ11: Trigger is internal half low-frequency clock
// RQ12: Overflow sets timer 1/0 flags bits 7/5
// RQ13: Run bits 6/4 start and stop timers
// RQ14: Hardware sets external interrupt flags bits 3/1
// RQ15: Type bits select falling edge or level
// RQ16: Service entry clears matching flags
// RQ17: Select bits 6/2 choose events or clocks
// RQ18: Mode fields choose 13/16/8-reload/split
// RQ19: Field 11 stops timer 1, splits timer 0
// RQ20: Timer 0 high byte at 0x8C, low separate
// RQ21: Timer 1 bytes at 0x8B and 0x8D
// RQ22: Timer mode increments every 12 cycles
// RQ23: Counter mode increments on pin falling edge
// RQ24: Mode 0 is 13-bit; low bits 7:5 kept
// RQ25: Gate bit needs interrupt pin high too
// RQ26: Split high byte uses timer 1 run/flag
`timescale 1ns/100ps
module mcu_timer_counters (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic isrAckTimer0,
  input wire logic isrAckTimer1,
  input wire logic isrAckExt0,
  input wire logic isrAckExt1,
  input wire logic timer0CountPin,
  input wire logic timer1CountPin,
  input wire logic extIrq0Pin,
  input wire logic extIrq1Pin,
  input wire logic timer2ExtInput,
  input wire logic lowFreqClock,
  output logic [7:0] sfrRdata,
  output logic timer0OvfFlag,
  output logic timer1OvfFlag,
  output logic extIrq0Flag,
  output logic extIrq1Flag,
  output logic timer1OverflowPulse,
  output logic timer2Overflow
);
  import timer_pkg::*;

  // Returns {overflow, high, low} after one count step
  function automatic logic [16:0] stepCount(input timer_mode_t mode, input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    logic [16:0] r;
    c13 = {1'b0, hi, lo[LOW13_BITS-1:0]} + 14'h1;
    c16 = {1'b0, hi, lo} + 17'h1;
    c8 = {1'b0, lo} + 9'h1;
    unique case (mode)
      MODE_13BIT: r = {c13[13], c13[12:LOW13_BITS], lo[7:LOW13_BITS],
                       c13[LOW13_BITS-1:0]}; // [RQ24]
      MODE_16BIT: r = c16;
      MODE_8BIT_RELOAD: r = {c8[8], hi, (c8[8] ? hi : c8[7:0])}; // [RQ1]
      MODE_SPLIT: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  function automatic timer_mode_t modeOf(input logic [1:0] field);
    return timer_mode_t'(field); // [RQ18]
  endfunction

  logic [7:0] ctrlFlags;
  logic [7:0] modeConfig;
  logic [7:0] t0Low;
  logic [7:0] t0High;
  logic [7:0] t1Low;
  logic [7:0] t1High;
  logic [7:0] t2Control;
  logic [15:0] reloadValue;
  logic [15:0] t2Count;
  logic [4:0] prescale;
  logic [PIN_COUNT-1:0] pinSample;
  logic [PIN_COUNT-1:0] pinPrev;
  logic [PIN_COUNT-1:0] pinFall;
  logic lfSample;
  logic lfPrev;
  logic lfHalf;
  logic lfHalfPrev;
  logic eventPending;
  logic tick12;
  logic tick24;
  logic tickT2;
  logic [1:0] irqSet;
  logic [7:0] next_ctrlFlags;
  logic [7:0] readData;

  assign timer0OvfFlag = ctrlFlags[T0_OVF_BIT];
  assign timer1OvfFlag = ctrlFlags[T1_OVF_BIT];
  assign extIrq0Flag = ctrlFlags[IRQ0_FLAG_BIT];
  assign extIrq1Flag = ctrlFlags[IRQ1_FLAG_BIT];

  // Pin sampling and falling-edge detection; idle-high reset so reset itself raises no event
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSample <= '1;
      pinPrev <= '1;
    end else begin
      pinSample <= {timer2ExtInput, extIrq1Pin, extIrq0Pin, timer1CountPin, timer0CountPin};
      pinPrev <= pinSample;
    end
  end
  assign pinFall = pinPrev & ~pinSample; // [RQ6] [RQ23]

  // Common prescaler: ticks every 12 and every 24 cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else if (prescale == PRESCALE_LAST) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 5'h1;
    end
  end
  assign tick12 = (prescale == PRESCALE_HALF) || (prescale == PRESCALE_LAST); // [RQ22]
  assign tick24 = (prescale == PRESCALE_LAST);

  // Timer 0 and timer 1 count control
  timer_mode_t t0Mode;
  timer_mode_t t1Mode;
  logic t0Split;
  logic t0Inc;
  logic t1Inc;
  logic th0SplitInc;
  logic [16:0] t0Step;
  logic [16:0] t1Step;
  logic t0LowOvf;
  logic t0HighOvf;
  logic t1Ovf;

  assign t0Mode = modeOf(modeConfig[TIMER0_OP_SELECT_HI:TIMER0_OP_SELECT_LO]);
  assign t1Mode = modeOf(modeConfig[TIMER1_OP_SELECT_HI:TIMER1_OP_SELECT_LO]);
  assign t0Split = (t0Mode == MODE_SPLIT); // [RQ19]
  assign t0Inc = ctrlFlags[T0_RUN_BIT]
                 && (!modeConfig[TIMER0_PIN_GATING_BIT] || pinSample[PIN_IRQ0])
                 && (modeConfig[CNT0_BIT] ? pinFall[PIN_T0] : tick12); // [RQ13] [RQ17] [RQ25]
  assign t1Inc = ctrlFlags[T1_RUN_BIT]
                 && (!modeConfig[TIMER1_PIN_GATING_BIT] || pinSample[PIN_IRQ1])
                 && (modeConfig[CNT1_BIT] ? pinFall[PIN_T1] : tick12); // [RQ13] [RQ17] [RQ25]
  assign th0SplitInc = t0Split && ctrlFlags[T1_RUN_BIT] && tick12; // [RQ26]
  assign t0Step = stepCount(t0Mode, t0High, t0Low);
  assign t1Step = stepCount(t1Mode, t1High, t1Low);
  assign t0LowOvf = t0Inc && (t0Split ? (t0Low == 8'hff) : t0Step[16]);
  assign t0HighOvf = th0SplitInc && (t0High == 8'hff);
  assign t1Ovf = t1Inc && t1Step[16]; // [RQ19]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t0Low <= REG_RESET;
    end else if (sfrWrite && sfrAddr == ADDR_T0_LOW) begin
      t0Low <= sfrWdata;
    end else if (t0Inc) begin
      t0Low <= t0Split ? t0Low + 8'h1 : t0Step[7:0]; // [RQ2]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t0High <= REG_RESET;
    end else if (sfrWrite && sfrAddr == ADDR_T0_HIGH) begin
      t0High <= sfrWdata; // [RQ20]
    end else if (th0SplitInc) begin
      t0High <= t0High + 8'h1; // [RQ2] [RQ26]
    end else if (!t0Split && t0Inc) begin
      t0High <= t0Step[15:8];
    end
  end

  // Timer 1 in split mode holds because stepCount returns the count unchanged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t1Low <= REG_RESET;
    end else if (sfrWrite && sfrAddr == ADDR_T1_LOW) begin
      t1Low <= sfrWdata; // [RQ21]
    end else if (t1Inc) begin
      t1Low <= t1Step[7:0]; // [RQ2]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t1High <= REG_RESET;
    end else if (sfrWrite && sfrAddr == ADDR_T1_HIGH) begin
      t1High <= sfrWdata; // [RQ21]
    end else if (t1Inc) begin
      t1High <= t1Step[15:8];
    end
  end

  // Timer 1 overflow stays visible for the baud rate path in every timer 1 mode except mode 3, where timer 1 holds
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer1OverflowPulse <= 1'b0;
    end else begin
      timer1OverflowPulse <= t1Ovf; // [RQ3]
    end
  end

  // External interrupt detection, edge or level per type bit
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_irq
      localparam int TYPE_BIT = (gi == 0) ? IRQ0_TYPE_BIT : IRQ1_TYPE_BIT;
      localparam int PIN_BIT = (gi == 0) ? PIN_IRQ0 : PIN_IRQ1;
      assign irqSet[gi] = ctrlFlags[TYPE_BIT] ? pinFall[PIN_BIT] : !pinSample[PIN_BIT]; // [RQ15]
    end
  endgenerate

  // Control flags: write, then service clears, then hardware sets win
  always_comb begin
    next_ctrlFlags = ctrlFlags;
    if (sfrWrite && sfrAddr == ADDR_CTRL_FLAGS) begin
      next_ctrlFlags = sfrWdata;
    end
    if (isrAckTimer0) begin
      next_ctrlFlags[T0_OVF_BIT] = 1'b0; // [RQ16]
    end
    if (isrAckTimer1) begin
      next_ctrlFlags[T1_OVF_BIT] = 1'b0; // [RQ16]
    end
    if (isrAckExt0) begin
      next_ctrlFlags[IRQ0_FLAG_BIT] = 1'b0; // [RQ16]
    end
    if (isrAckExt1) begin
      next_ctrlFlags[IRQ1_FLAG_BIT] = 1'b0; // [RQ16]
    end
    if (t0LowOvf) begin
      next_ctrlFlags[T0_OVF_BIT] = 1'b1; // [RQ12]
    end
    if (t0Split ? t0HighOvf : t1Ovf) begin
      next_ctrlFlags[T1_OVF_BIT] = 1'b1; // [RQ3] [RQ12] [RQ26]
    end
    if (irqSet[0]) begin
      next_ctrlFlags[IRQ0_FLAG_BIT] = 1'b1; // [RQ14]
    end
    if (irqSet[1]) begin
      next_ctrlFlags[IRQ1_FLAG_BIT] = 1'b1; // [RQ14]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlFlags <= REG_RESET;
    end else begin
      ctrlFlags <= next_ctrlFlags;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeConfig <= REG_RESET;
      t2Control <= REG_RESET;
      reloadValue <= RELOAD_RESET;
    end else if (sfrWrite) begin
      if (sfrAddr == ADDR_MODE_CONFIG) begin
        modeConfig <= sfrWdata;
      end
      if (sfrAddr == ADDR_T2_CONTROL) begin
        t2Control <= sfrWdata;
      end
      if (sfrAddr == ADDR_RELOAD_LOW) begin
        reloadValue[7:0] <= sfrWdata;
      end
      if (sfrAddr == ADDR_RELOAD_HIGH) begin
        reloadValue[15:8] <= sfrWdata;
      end
    end
  end

  // Internal reload trigger: low-frequency clock divided by two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lfSample <= 1'b0;
      lfPrev <= 1'b0;
      lfHalf <= 1'b0;
      lfHalfPrev <= 1'b0;
    end else begin
      lfSample <= lowFreqClock;
      lfPrev <= lfSample;
      lfHalfPrev <= lfHalf;
      if (lfSample && !lfPrev) begin
        lfHalf <= !lfHalf; // [RQ11]
      end
    end
  end

  // Timer 2
  t2_input_t t2Sel;
  logic [1:0] reloadMode;
  logic t2Inc;
  logic t2Wrap;
  logic trigReload;

  assign t2Sel = t2_input_t'(t2Control[INSEL_HI:INSEL_LO]);
  assign reloadMode = t2Control[RELOAD_HI:RELOAD_LO];
  assign tickT2 = t2Control[PRESCALE_BIT] ? tick24 : tick12; // [RQ5]
  assign trigReload = (reloadMode == RELOAD_ON_TRIGGER) && lfHalfPrev && !lfHalf; // [RQ10]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eventPending <= 1'b0;
    end else begin
      eventPending <= (t2Sel == T2_EVENT) && pinFall[PIN_T2]; // [RQ6] [RQ7]
    end
  end

  always_comb begin
    unique case (t2Sel)
      T2_STOPPED: t2Inc = 1'b0;
      T2_TIMER: t2Inc = tickT2; // [RQ5]
      T2_EVENT: t2Inc = eventPending; // [RQ7]
      T2_GATED: t2Inc = tickT2 && pinSample[PIN_T2]; // [RQ8]
    endcase
  end
  assign t2Wrap = t2Inc && (t2Count == 16'hffff);

  // Count is read live, so reads never pause the timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t2Count <= RELOAD_RESET;
    end else if (sfrWrite && sfrAddr == ADDR_T2_LOW) begin
      t2Count[7:0] <= sfrWdata;
    end else if (sfrWrite && sfrAddr == ADDR_T2_HIGH) begin
      t2Count[15:8] <= sfrWdata;
    end else if (trigReload) begin
      t2Count <= reloadValue; // [RQ10]
    end else if (t2Inc) begin
      t2Count <= (t2Wrap && reloadMode == RELOAD_ON_OVF) ? reloadValue
                                                          : t2Count + 16'h1; // [RQ4] [RQ9]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer2Overflow <= 1'b0;
    end else begin
      timer2Overflow <= t2Wrap;
    end
  end

  // Register read, one cycle after the address
  always_comb begin
    unique case (sfrAddr)
      ADDR_CTRL_FLAGS: readData = ctrlFlags;
      ADDR_MODE_CONFIG: readData = modeConfig;
      ADDR_T0_LOW: readData = t0Low;
      ADDR_T1_LOW: readData = t1Low;
      ADDR_T0_HIGH: readData = t0High;
      ADDR_T1_HIGH: readData = t1High;
      ADDR_T2_CONTROL: readData = t2Control;
      ADDR_RELOAD_LOW: readData = reloadValue[7:0];
      ADDR_RELOAD_HIGH: readData = reloadValue[15:8];
      ADDR_T2_LOW: readData = t2Count[7:0]; // [RQ4]
      ADDR_T2_HIGH: readData = t2Count[15:8];
      default: readData = REG_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdata <= REG_RESET;
    end else begin
      sfrRdata <= readData;
    end
  end

  AST_T0_OVF_SETS_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // [RQ12]
    t0LowOvf |=> ctrlFlags[T0_OVF_BIT])
    else $error("timer 0 overflow did not set its flag");

  AST_T0_STOPPED: assert property (@(posedge clk) disable iff (!reset_n) // [RQ13]
    !ctrlFlags[T0_RUN_BIT] && !(sfrWrite && sfrAddr == ADDR_T0_LOW) |=> $stable(t0Low))
    else $error("timer 0 low byte moved while stopped");

  AST_T1_SPLIT_HOLDS: assert property (@(posedge clk) disable iff (!reset_n) // [RQ2]
    t1Mode == MODE_SPLIT && !sfrWrite |=> $stable(t1Low) && $stable(t1High))
    else $error("timer 1 changed in mode 3");

  AST_MODE2_RELOAD: assert property (@(posedge clk) disable iff (!reset_n) // [RQ1]
    t0Mode == MODE_8BIT_RELOAD && t0Inc && t0Low == 8'hff && !sfrWrite
    |=> t0Low == $past(t0High))
    else $error("timer 0 mode 2 did not reload");

  AST_SPLIT_T1_SILENT: assert property (@(posedge clk) disable iff (!reset_n) // [RQ3]
    t0Split && !t0HighOvf && !ctrlFlags[T1_OVF_BIT]
    && !(sfrWrite && sfrAddr == ADDR_CTRL_FLAGS) |=> !ctrlFlags[T1_OVF_BIT])
    else $error("timer 1 flag set while timer 0 split");

  AST_T2_EVENT_NEXT: assert property (@(posedge clk) disable iff (!reset_n) // [RQ7]
    t2Sel == T2_EVENT && pinFall[PIN_T2] && !(sfrWrite && sfrAddr == ADDR_T2_CONTROL)
    |=> t2Inc)
    else $error("event count not applied in next cycle");

  AST_T2_GATED_LOW: assert property (@(posedge clk) disable iff (!reset_n) // [RQ8]
    t2Sel == T2_GATED && !pinSample[PIN_T2] |-> !t2Inc)
    else $error("gated timer 2 counted with input low");

  AST_T2_DIV12: assert property (@(posedge clk) disable iff (!reset_n) // [RQ5]
    t2Sel == T2_TIMER && !t2Control[PRESCALE_BIT] && t2Inc && !sfrWrite
    |=> (!t2Inc) [*8])
    else $error("timer 2 counted too fast");

  AST_T2_OVF_RELOAD: assert property (@(posedge clk) disable iff (!reset_n) // [RQ9]
    t2Wrap && reloadMode == RELOAD_ON_OVF && !sfrWrite |=> t2Count == $past(reloadValue))
    else $error("timer 2 did not reload on overflow");

  AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!reset_n) // [RQ16]
    isrAckTimer0 && !t0LowOvf && !(sfrWrite && sfrAddr == ADDR_CTRL_FLAGS)
    |=> !ctrlFlags[T0_OVF_BIT])
    else $error("service entry did not clear timer 0 flag");

  AST_EDGE_IRQ: assert property (@(posedge clk) disable iff (!reset_n) // [RQ14]
    ctrlFlags[IRQ0_TYPE_BIT] && pinFall[PIN_IRQ0] |=> ctrlFlags[IRQ0_FLAG_BIT])
    else $error("falling edge did not set interrupt 0 flag");
endmodule

// >>> hdl/timer_pkg.sv
// Shared addresses, bit positions, encodings and counts for the timer/counter block
package timer_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_CTRL_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_T2_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_T2_LOW = 8'hcc;
  localparam logic [7:0] ADDR_T2_HIGH = 8'hcd;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // timer_ctrl_flags fields
  localparam int T1_OVF_BIT = 7;
  localparam int T1_RUN_BIT = 6;
  localparam int T0_OVF_BIT = 5;
  localparam int T0_RUN_BIT = 4;
  localparam int IRQ1_FLAG_BIT = 3;
  localparam int IRQ1_TYPE_BIT = 2;
  localparam int IRQ0_FLAG_BIT = 1;
  localparam int IRQ0_TYPE_BIT = 0;

  // timer_mode_config fields
  localparam int TIMER1_PIN_GATING_BIT = 7;
  localparam int CNT1_BIT = 6;
  localparam int TIMER1_OP_SELECT_HI = 5;
  localparam int TIMER1_OP_SELECT_LO = 4;
  localparam int TIMER0_PIN_GATING_BIT = 3;
  localparam int CNT0_BIT = 2;
  localparam int TIMER0_OP_SELECT_HI = 1;
  localparam int TIMER0_OP_SELECT_LO = 0;
  localparam int LOW13_BITS = 5;

  // timer2_control fields
  localparam int PRESCALE_BIT = 7;
  localparam int RELOAD_HI = 4;
  localparam int RELOAD_LO = 3;
  localparam int INSEL_HI = 1;
  localparam int INSEL_LO = 0;
  localparam logic [1:0] RELOAD_ON_OVF = 2'h2;
  localparam logic [1:0] RELOAD_ON_TRIGGER = 2'h3;

  // Sampled pin positions
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_IRQ0 = 2;
  localparam int PIN_IRQ1 = 3;
  localparam int PIN_T2 = 4;
  localparam int PIN_COUNT = 5;

  // Prescaler
  localparam int DIV12_CYCLES = 12;
  localparam int DIV24_CYCLES = 24;
  localparam logic [4:0] PRESCALE_HALF = 5'(DIV12_CYCLES - 1);
  localparam logic [4:0] PRESCALE_LAST = 5'(DIV24_CYCLES - 1);

  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_8BIT_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } timer_mode_t;

  typedef enum logic [1:0] {
    T2_STOPPED = 2'h0,
    T2_TIMER = 2'h1,
    T2_EVENT = 2'h2,
    T2_GATED = 2'h3
  } t2_input_t;
endpackage

// >>> test/mcu_timer_counters_tb_top.sv
// Self-checking bench for the timer/counter block
`timescale 1ns/100ps
module mcu_timer_counters_tb_top;
  import timer_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata;
  logic sfrWrite, rdTag;
  logic rdFlag = 1'b0;
  logic irq0Pin = 1'b1;
  logic irq1Pin = 1'b1;
  logic t1Pin = 1'b1;
  logic lfClk = 1'b0;
  logic [1:0] evPins = 2'b11;
  logic [3:0] ackBus;
  wire [5:0] outs;
  logic [7:0] expQ[$];
  logic [7:0] lowExp[3] = '{8'he0, 8'h00, 8'h80};
  logic [7:0] rstAddr[12] = '{ADDR_CTRL_FLAGS, ADDR_MODE_CONFIG, ADDR_T0_LOW, ADDR_T1_LOW,
    ADDR_T0_HIGH, ADDR_T1_HIGH, ADDR_T2_CONTROL, ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH,
    ADDR_T2_LOW, ADDR_T2_HIGH, 8'h90};
  int fails = 0;
  int n_compared = 0;

  mcu_timer_counters dut_u (.clk(clk), .reset_n(reset_n), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .isrAckTimer0(ackBus[0]),
    .isrAckTimer1(ackBus[1]), .isrAckExt0(ackBus[2]), .isrAckExt1(ackBus[3]),
    .timer0CountPin(evPins[0]), .timer1CountPin(t1Pin), .extIrq0Pin(irq0Pin),
    .extIrq1Pin(irq1Pin), .timer2ExtInput(evPins[1]), .lowFreqClock(lfClk),
    .sfrRdata(sfrRdata), .timer0OvfFlag(outs[0]), .timer1OvfFlag(outs[1]),
    .extIrq0Flag(outs[2]), .extIrq1Flag(outs[3]), .timer1OverflowPulse(outs[4]),
    .timer2Overflow(outs[5]));
  sfr_core_model core_u (.clk(clk), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .ackBus(ackBus), .rdTag(rdTag));

  initial begin
    forever #20 clk = ~clk;
  end

  // Slow clock runs free, ten fast cycles per period
  initial begin
    forever begin
      repeat (5) @(posedge clk);
      lfClk <= ~lfClk;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data lands one edge after the address; compare at the following low phase
  always @(posedge clk) rdFlag <= rdTag;
  always @(negedge clk) begin
    if (rdFlag === 1'b1)
      check(sfrRdata, expQ.pop_front());
  end

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    core_u.rd(a);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Watch one output for a bounded span, stop at the first high, compare whether seen
  task automatic waitBit(input int i, input int lim, input logic e);
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      @(negedge clk);
      if (outs[i] === 1'b1)
        seen = 1'b1;
    end
    check({7'h00, seen}, {7'h00, e});
  endtask

  task automatic pulses(input int which, input int n);
    repeat (n) begin
      @(posedge clk);
      evPins[which] <= 1'b0;
      cyc(2);
      evPins[which] <= 1'b1;
      cyc(2);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #800000;
    fails++;
    stop_test();
  end

  initial begin
    logic [7:0] v;
    void'($urandom(60));
    cyc(16);
    reset_n <= 1'b1;
    foreach (rstAddr[i]) rdx(rstAddr[i], REG_RESET);
    core_u.wr(8'h90, 8'ha5);
    rdx(8'h90, 8'h00);
    for (int i = 1; i < 6; i++) begin
      v = 8'($urandom);
      core_u.wr(rstAddr[i], v);
      rdx(rstAddr[i], v);
    end
    done("registers");
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 3; m++) begin
        core_u.wr(ADDR_MODE_CONFIG, 8'(m << (4 * t)));
        core_u.wr(t ? ADDR_T1_LOW : ADDR_T0_LOW, 8'hff);
        core_u.wr(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, m == 2 ? 8'h80 : 8'hff);
        core_u.wr(ADDR_CTRL_FLAGS, 8'(8'h10 << (2 * t)));
        waitBit(t, 30, 1'b1);
        core_u.wr(ADDR_CTRL_FLAGS, 8'(8'h20 << (2 * t)));
        rdx(t ? ADDR_T1_LOW : ADDR_T0_LOW, lowExp[m]);
        rdx(t ? ADDR_T1_HIGH : ADDR_T0_HIGH, m == 2 ? 8'h80 : 8'h00);
        core_u.ack(t);
        waitBit(t, 3, 1'b0);
        core_u.wr(ADDR_CTRL_FLAGS, 8'h00);
      end
    end
    done("modes");
    core_u.wr(ADDR_MODE_CONFIG, 8'h30);
    core_u.wr(ADDR_T1_LOW, 8'h55);
    core_u.wr(ADDR_CTRL_FLAGS, 8'h40);
    cyc(40);
    rdx(ADDR_T1_LOW, 8'h55);
    core_u.wr(ADDR_T0_LOW, 8'h00);
    core_u.wr(ADDR_T0_HIGH, 8'hff);
    core_u.wr(ADDR_MODE_CONFIG, 8'h03);
    waitBit(1, 30, 1'b1);
    rdx(ADDR_T0_LOW, 8'h00);
    core_u.wr(ADDR_CTRL_FLAGS, 8'h00);
    core_u.wr(ADDR_T1_LOW, 8'hff);
    core_u.wr(ADDR_T1_HIGH, 8'hff);
    core_u.wr(ADDR_CTRL_FLAGS, 8'h40);
    waitBit(4, 30, 1'b1);
    rdx(ADDR_CTRL_FLAGS, 8'h40);
    core_u.wr(ADDR_CTRL_FLAGS, 8'h00);
    done("split");
    core_u.wr(ADDR_MODE_CONFIG, 8'h05);
    core_u.wr(ADDR_T0_LOW, 8'h00);
    core_u.wr(ADDR_CTRL_FLAGS, 8'h10);
    pulses(0, 5);
    cyc(3);
    rdx(ADDR_T0_LOW, 8'h05);
    core_u.wr(ADDR_MODE_CONFIG, 8'h0d);
    irq0Pin <= 1'b0;
    pulses(0, 3);
    cyc(3);
    rdx(ADDR_T0_LOW, 8'h05);
    irq0Pin <= 1'b1;
    pulses(0, 2);
    cyc(3);
    rdx(ADDR_T0_LOW, 8'h07);
    done("counter");
    core_u.wr(ADDR_CTRL_FLAGS, 8'h01);
    waitBit(2, 4, 1'b0);
    cyc(1);
    irq0Pin <= 1'b0;
    waitBit(2, 4, 1'b1);
    core_u.ack(2);
    waitBit(2, 4, 1'b0);
    core_u.wr(ADDR_CTRL_FLAGS, 8'h00);
    waitBit(2, 4, 1'b1);
    cyc(1);
    irq0Pin <= 1'b1;
    irq1Pin <= 1'b0;
    waitBit(3, 4, 1'b1);
    cyc(1);
    irq1Pin <= 1'b1;
    core_u.ack(3);
    waitBit(3, 4, 1'b0);
    done("interrupts");
    core_u.wr(ADDR_RELOAD_LOW, 8'h34);
    core_u.wr(ADDR_RELOAD_HIGH, 8'h12);
    for (int p = 0; p < 2; p++) begin
      core_u.wr(ADDR_T2_LOW, 8'hff);
      core_u.wr(ADDR_T2_HIGH, 8'hff);
      core_u.wr(ADDR_T2_CONTROL, p ? 8'h81 : 8'h11);
      waitBit(5, 60, 1'b1);
      cyc(p ? 228 : 114);
      rdx(ADDR_T2_LOW, p ? 8'h09 : 8'h3d);
      rdx(ADDR_T2_HIGH, p ? 8'h00 : 8'h12);
    end
    done("timer2 prescale");
    evPins[1] <= 1'b0;
    core_u.wr(ADDR_T2_CONTROL, 8'h03);
    core_u.wr(ADDR_T2_LOW, 8'hff);
    core_u.wr(ADDR_T2_HIGH, 8'hff);
    waitBit(5, 60, 1'b0);
    cyc(1);
    evPins[1] <= 1'b1;
    waitBit(5, 30, 1'b1);
    core_u.wr(ADDR_T2_CONTROL, 8'h02);
    core_u.wr(ADDR_T2_LOW, 8'h00);
    core_u.wr(ADDR_T2_HIGH, 8'h00);
    pulses(1, 4);
    cyc(4);
    rdx(ADDR_T2_LOW, 8'h04);
    done("timer2 gate and event");
    core_u.wr(ADDR_T2_CONTROL, 8'h18);
    core_u.wr(ADDR_T2_LOW, 8'h00);
    cyc(50);
    rdx(ADDR_T2_LOW, 8'h34);
    rdx(ADDR_T2_HIGH, 8'h12);
    done("timer2 trigger");
    stop_test();
  end
endmodule

// >>> test/sfr_core_model.sv
// Core-side model that drives the special function register bus and service entries
`timescale 1ns/100ps
module sfr_core_model (
  input wire logic clk,
  output logic [7:0] sfrAddr,
  output logic sfrWrite,
  output logic [7:0] sfrWdata,
  output logic [3:0] ackBus,
  output logic rdTag
);
  initial begin
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrWdata = 8'h00;
    ackBus = 4'h0;
    rdTag = 1'b0;
  end

  // One-cycle write strobe; data is inverted after release so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrite <= 1'b1;
    sfrWdata <= d;
    @(posedge clk);
    sfrWrite <= 1'b0;
    sfrAddr <= 8'h00;
    sfrWdata <= ~d;
  endtask

  // Address for one cycle; rdTag marks the cycle whose read data follows
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfrAddr <= a;
    rdTag <= 1'b1;
    @(posedge clk);
    rdTag <= 1'b0;
    sfrAddr <= 8'h00;
  endtask

  task automatic ack(input int idx);
    @(posedge clk);
    ackBus[idx] <= 1'b1;
    @(posedge clk);
    ackBus <= 4'h0;
  endtask
endmodule
